// File: verilog/tlsc_pkg.sv
// constants shared by both ends of the three-line serial control link
// assumes a 125 MHz system clock on each end and a pulled-up data line
package tlsc_pkg;
  // field widths on the wire
  localparam int ID_W = 6;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  // prefix that opens every transfer
  localparam logic [1:0] PREFIX = 2'h1;
  // bit positions in the header, counted from 0 after the strobe falls
  localparam logic [4:0] HB_PFX_END = 5'h01;
  localparam logic [4:0] HB_ID_END = 5'h07;
  localparam logic [4:0] HB_END = 5'h08;
  // bit positions inside one register frame
  localparam logic [4:0] FB_DIR = 5'h00;
  localparam logic [4:0] FB_ADDR_END = 5'h07;
  localparam logic [4:0] FB_TURN = 5'h08;
  localparam logic [4:0] FB_DATA_FIRST = 5'h09;
  localparam logic [4:0] FB_DATA_END = 5'h10;
  localparam logic [4:0] FB_END = 5'h11;
  // register addresses
  localparam logic [6:0] A_RESET = 7'h00;
  localparam logic [6:0] A_ID = 7'h01;
  localparam logic [6:0] A_BLOCK = 7'h03;
  localparam logic [6:0] A_FILTER = 7'h05;
  localparam logic [6:0] A_VCO = 7'h06;
  // register defaults
  localparam logic [7:0] D_BLOCK = 8'h08;
  localparam logic [7:0] D_FILTER = 8'h1c;
  localparam logic [7:0] D_VCO = 8'h0b;
  // serial clock timing made by the host
  localparam int CLK_NS = 8;
  localparam int SCLK_HALF_NS = 80;
  localparam int HALF_CYC_I = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] HALF_CYC = 5'(HALF_CYC_I);
  // host samples returned data this many cycles after its falling edge
  localparam logic [4:0] SAMPLE_DLY = 5'h02;
  // bits in a one-frame transfer: header 9, frame 18
  localparam logic [4:0] TX_BITS = 5'h1b;
  // direction bit values
  localparam logic DIR_WRITE = 1'b1;
  localparam logic DIR_READ = 1'b0;
endpackage

// File: verilog/tlsc_if.sv
// pins of the three-line link, with the open-drain data wire resolved here
// assumes an external pull-up: the wire is low only while some end pulls it
`timescale 1ns/100ps
`default_nettype none
interface tlsc_if;
  logic frame_strobe; // low while a transfer runs, host drives
  logic sclk; // serial clock, host drives
  logic host_sda_o; // host data value, always low
  logic host_sda_oe; // host pulls data low
  logic dev_sda_o; // device data value, always low
  logic dev_sda_oe; // device pulls data low
  logic sda; // resolved data line level
  // wired-and with pull-up
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport dev (input frame_strobe, input sclk, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (output frame_strobe, output sclk, output host_sda_o, output host_sda_oe,
    input sda);
endinterface
`default_nettype wire

// File: verilog/tlsc_host.sv
// master end: makes strobe and serial clock, sends one frame per request
// assumes the device answers read data on the clock's rising edge
`timescale 1ns/100ps
`default_nettype none
module tlsc_host (
  input wire logic clock,
  input wire logic srst,
  tlsc_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [5:0] req_id,
  input wire logic [6:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata
);
  typedef enum logic [2:0] {TH_GAP, TH_IDLE, TH_LEAD, TH_HI, TH_LO, TH_TAIL} tlsc_hst_t;
  tlsc_hst_t st_r; // sequencer state
  logic [4:0] tick_r; // cycles spent in current half period
  logic [4:0] bit_r; // index of bit on the wire
  logic [26:0] tx_r; // bits to send, first bit at the top
  logic rd_r; // transfer is a read
  logic [7:0] rx_r; // read data being gathered
  logic [2:0] sync_r; // data line synchroniser, stage 0 read only by stage 1
  logic strobe_r; // strobe pin
  logic sclk_r; // clock pin
  logic pull_r; // host pulls data low
  logic half_done; // end of a half period
  assign half_done = (tick_r == tlsc_pkg::HALF_CYC - 5'h01);
  assign req_ready = (st_r == TH_IDLE) ? 1'b1 : 1'b0;
  assign link.frame_strobe = strobe_r;
  assign link.sclk = sclk_r;
  assign link.host_sda_o = 1'b0; // never driven high
  assign link.host_sda_oe = pull_r;
  // three flops on the returned data line
  always_ff @(posedge clock) begin
    if (srst) begin
      sync_r <= 3'h7;
    end else begin
      sync_r <= {sync_r[1:0], link.sda};
    end
  end
  // half period counter and sequencer
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= TH_GAP;
      tick_r <= 5'h00;
      bit_r <= 5'h00;
    end else begin
      tick_r <= (st_r == TH_IDLE || half_done) ? 5'h00 : tick_r + 5'h01;
      unique case (st_r)
        TH_GAP: if (tick_r == tlsc_pkg::HALF_CYC - 5'h01 && bit_r == 5'h01) begin
          st_r <= TH_IDLE; // all lines high for a whole period
        end else if (half_done) begin
          bit_r <= bit_r + 5'h01;
        end
        TH_IDLE: if (req_valid) begin
          st_r <= TH_LEAD; // strobe falls first
          bit_r <= 5'h00;
        end
        TH_LEAD: if (half_done) st_r <= TH_HI;
        TH_HI: if (half_done) st_r <= TH_LO;
        TH_LO: if (half_done) begin
          if (bit_r == tlsc_pkg::TX_BITS - 5'h01) begin
            st_r <= TH_TAIL; // clock high one more half period
          end else begin
            st_r <= TH_HI;
            bit_r <= bit_r + 5'h01;
          end
        end
        TH_TAIL: if (half_done) begin
          st_r <= TH_GAP;
          bit_r <= 5'h00;
        end
      endcase
    end
  end
  // pin drive: data changes only while the clock is high
  always_ff @(posedge clock) begin
    if (srst) begin
      strobe_r <= 1'b1;
      sclk_r <= 1'b1;
      pull_r <= 1'b0;
      tx_r <= '1;
      rd_r <= 1'b0;
    end else begin
      if (st_r == TH_IDLE && req_valid) begin
        strobe_r <= 1'b0;
        // prefix, id, dummy, dir, addr, dummy, data, dummy, msb first
        tx_r <= {tlsc_pkg::PREFIX, req_id, 1'b1, req_write, req_addr, 1'b1,
          (req_write ? req_wdata : 8'hff), 1'b1};
        rd_r <= ~req_write;
      end
      if ((st_r == TH_LEAD || st_r == TH_LO) && half_done && st_r != TH_TAIL) begin
        if (st_r == TH_LO && bit_r == tlsc_pkg::TX_BITS - 5'h01) begin
          pull_r <= 1'b0; // release after last bit
          sclk_r <= 1'b1;
        end else begin
          pull_r <= ~tx_r[26]; // open drain: only pull low
          tx_r <= {tx_r[25:0], 1'b1};
          sclk_r <= 1'b1;
        end
      end else if (st_r == TH_HI && half_done) begin
        sclk_r <= 1'b0; // falling edge, receiver samples here
      end else if (st_r == TH_TAIL && half_done) begin
        strobe_r <= 1'b1; // strobe rises with clock high
      end
    end
  end
  // gather read data after each falling edge
  always_ff @(posedge clock) begin
    if (srst) begin
      rx_r <= 8'h00;
      rsp_valid <= 1'b0;
      rsp_rdata <= 8'h00;
    end else begin
      rsp_valid <= 1'b0;
      // data byte lies one header length plus the frame data offset into the transfer
      if (st_r == TH_LO && tick_r == tlsc_pkg::SAMPLE_DLY && rd_r &&
          bit_r >= tlsc_pkg::HB_END + tlsc_pkg::FB_DATA_FIRST + 5'h01 &&
          bit_r <= tlsc_pkg::HB_END + tlsc_pkg::FB_DATA_END + 5'h01) begin
        rx_r <= {rx_r[6:0], sync_r[2]}; // msb first
      end
      if (st_r == TH_TAIL && half_done) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= rd_r ? rx_r : 8'h00;
      end
    end
  end
endmodule
`default_nettype wire

// File: verilog/tlsc_dev.sv
// slave end of the three-line serial control link with its control registers
// assumes the host makes strobe and clock, both far slower than this clock;
// every pin is brought in through two flops before use
`timescale 1ns/100ps
`default_nettype none
module tlsc_dev #(
  parameter logic [5:0] SLAVE_ID = 6'h15 // arbitrary identity value
) (
  input wire logic clock,
  input wire logic srst,
  tlsc_if.dev link,
  output logic [7:0] block_ctl,
  output logic [7:0] filter_sel,
  output logic [7:0] vco_ctl,
  output logic busy
);
  // transfer progress
  typedef enum logic [1:0] {TD_IDLE, TD_HDR, TD_FRAME, TD_SKIP} tlsc_dst_t;

  tlsc_dst_t st_r; // where in the transfer we are
  logic [4:0] cnt_r; // index of the next bit to be sampled
  logic [6:0] sh_r; // incoming shift register
  logic dir_r; // direction of the current frame
  logic [6:0] addr_r; // address of the current frame
  logic [7:0] out_r; // outgoing read byte, top bit next
  logic drv_r; // device pulls data low
  logic [7:0] block_r; // block control register
  logic [7:0] filter_r; // filter select register
  logic [7:0] vco_r; // oscillator control register
  logic [1:0] fs_s; // strobe synchroniser
  logic [1:0] ck_s; // clock synchroniser
  logic [1:0] da_s; // data synchroniser
  logic fs_d; // strobe, one cycle later, for edges
  logic ck_d; // clock, one cycle later, for edges
  logic fs_fall; // strobe went low
  logic ck_fall; // serial clock fell
  logic ck_rise; // serial clock rose
  logic bit_in; // sampled data bit
  logic [7:0] rd_byte; // read answer for the current address

  // read mux over the register map
  function automatic logic [7:0] read_reg(input logic [6:0] a, input logic [7:0] b,
    input logic [7:0] f, input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00; // unmapped and reset address read as zero
    unique case (a)
      tlsc_pkg::A_ID: r = {2'h0, SLAVE_ID}; // own id in low bits
      tlsc_pkg::A_BLOCK: r = b;
      tlsc_pkg::A_FILTER: r = f;
      tlsc_pkg::A_VCO: r = v;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // true while the frame bit index lies in the data byte
  function automatic logic in_data(input logic [4:0] c);
    return (c >= tlsc_pkg::FB_DATA_FIRST) && (c <= tlsc_pkg::FB_DATA_END);
  endfunction

  // two flops on every pin before any logic reads it
  always_ff @(posedge clock) begin
    if (srst) begin
      fs_s <= 2'h3;
      ck_s <= 2'h3;
      da_s <= 2'h3;
    end else begin
      fs_s <= {fs_s[0], link.frame_strobe};
      ck_s <= {ck_s[0], link.sclk};
      da_s <= {da_s[0], link.sda};
    end
  end

  // delayed copies for edge detection, taken from the second stage only
  always_ff @(posedge clock) begin
    if (srst) begin
      fs_d <= 1'b1;
      ck_d <= 1'b1;
    end else begin
      fs_d <= fs_s[1];
      ck_d <= ck_s[1];
    end
  end

  // edge strobes, one cycle each
  assign fs_fall = fs_d & ~fs_s[1];
  assign ck_fall = ck_d & ~ck_s[1] & ~fs_s[1]; // clocks count only while the strobe is low
  assign ck_rise = ~ck_d & ck_s[1] & ~fs_s[1];
  assign bit_in = da_s[1];
  assign rd_byte = read_reg(addr_r, block_r, filter_r, vco_r);

  // transfer sequencer, advanced on each falling serial clock edge
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= TD_IDLE;
      cnt_r <= 5'h00;
      sh_r <= 7'h00;
      dir_r <= tlsc_pkg::DIR_WRITE;
      addr_r <= 7'h00;
    end else if (fs_s[1]) begin
      st_r <= TD_IDLE; // strobe high: all activity ignored
      cnt_r <= 5'h00;
    end else if (fs_fall) begin
      st_r <= TD_HDR; // new transfer, counting restarts
      cnt_r <= 5'h00;
    end else if (ck_fall) begin
      sh_r <= {sh_r[5:0], bit_in}; // sampled on falling edge, msb first
      unique case (st_r)
        TD_HDR: begin
          cnt_r <= cnt_r + 5'h01;
          if (cnt_r == tlsc_pkg::HB_PFX_END && {sh_r[0], bit_in} != tlsc_pkg::PREFIX) begin
            st_r <= TD_SKIP; // bad prefix refused
          end else if (cnt_r == tlsc_pkg::HB_ID_END && {sh_r[4:0], bit_in} != SLAVE_ID) begin
            st_r <= TD_SKIP; // other slave addressed
          end else if (cnt_r == tlsc_pkg::HB_END) begin
            st_r <= TD_FRAME; // dummy bit skipped, frame follows
            cnt_r <= tlsc_pkg::FB_DIR;
          end
        end
        TD_FRAME: begin
          if (cnt_r == tlsc_pkg::FB_DIR) begin
            dir_r <= bit_in; // 1 host writes, 0 device answers
          end
          if (cnt_r == tlsc_pkg::FB_ADDR_END) begin
            addr_r <= {sh_r[5:0], bit_in}; // one of 128 addresses
          end
          if (cnt_r == tlsc_pkg::FB_END) begin
            cnt_r <= tlsc_pkg::FB_DIR; // another frame may follow
          end else begin
            cnt_r <= cnt_r + 5'h01;
          end
        end
        TD_SKIP: cnt_r <= cnt_r; // silent until strobe rises
        TD_IDLE: cnt_r <= cnt_r;
      endcase
    end
  end

  // control registers: written at the last data bit of a write frame
  always_ff @(posedge clock) begin
    if (srst) begin
      block_r <= tlsc_pkg::D_BLOCK;
      filter_r <= tlsc_pkg::D_FILTER;
      vco_r <= tlsc_pkg::D_VCO;
    end else if (ck_fall && st_r == TD_FRAME && dir_r == tlsc_pkg::DIR_WRITE &&
        cnt_r == tlsc_pkg::FB_DATA_END) begin
      unique case (addr_r)
        tlsc_pkg::A_RESET: begin
          block_r <= tlsc_pkg::D_BLOCK; // any write here restores defaults
          filter_r <= tlsc_pkg::D_FILTER;
          vco_r <= tlsc_pkg::D_VCO;
        end
        tlsc_pkg::A_BLOCK: block_r <= {sh_r, bit_in}; // store master byte
        tlsc_pkg::A_FILTER: filter_r <= {sh_r, bit_in};
        tlsc_pkg::A_VCO: vco_r <= {sh_r, bit_in};
        default: block_r <= block_r; // read-only or unmapped: no change
      endcase
    end
  end

  // read byte: loaded at the turnaround bit, shifted after each data bit
  always_ff @(posedge clock) begin
    if (srst) begin
      out_r <= 8'hff;
    end else if (ck_fall && st_r == TD_FRAME) begin
      if (cnt_r == tlsc_pkg::FB_TURN) begin
        out_r <= rd_byte; // addressed contents shifted out
      end else if (in_data(cnt_r)) begin
        out_r <= {out_r[6:0], 1'b1}; // msb first
      end
    end
  end

  // data pin: changes only after rising edges, steady over the falling edge
  always_ff @(posedge clock) begin
    if (srst) begin
      drv_r <= 1'b0;
    end else if (fs_s[1] || st_r != TD_FRAME) begin
      drv_r <= 1'b0; // released outside a matched transfer
    end else if (ck_rise) begin
      if (dir_r == tlsc_pkg::DIR_READ && in_data(cnt_r)) begin
        drv_r <= ~out_r[7]; // pull low for a zero only
      end else begin
        drv_r <= 1'b0; // released after the byte group
      end
    end
  end

  // outputs
  assign link.dev_sda_o = 1'b0; // line is never driven high
  assign link.dev_sda_oe = drv_r;
  assign block_ctl = block_r;
  assign filter_sel = filter_r;
  assign vco_ctl = vco_r;
  assign busy = (st_r != TD_IDLE) ? 1'b1 : 1'b0;
endmodule
`default_nettype wire

// File: test/tlsc_link_sva.sv
// concurrent checks on the link that joins the host end to the device end
// assumes it sees the interface signals directly, all in the clock domain
`timescale 1ns/100ps
`default_nettype none
module tlsc_link_sva (
  input wire logic clock,
  input wire logic srst,
  input wire logic frame_strobe,
  input wire logic sclk,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  logic sclk_q_r; // serial clock one cycle late
  logic [5:0] fall_cnt_r; // serial clock falls seen under the strobe
  logic [7:0] idle_cnt_r; // length of the current all-high stretch of the three lines
  localparam int IDLE_MIN = 2 * tlsc_pkg::HALF_CYC_I; // one serial clock period in cycles
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // count bit edges of one transfer, cleared while the strobe is high
  always_ff @(posedge clock) begin
    sclk_q_r <= sclk;
    if (srst || frame_strobe) begin
      fall_cnt_r <= 6'h00;
    end else if (sclk_q_r && !sclk) begin
      fall_cnt_r <= fall_cnt_r + 6'h01;
    end
  end
  // count cycles with strobe, clock and data all high, saturating
  always_ff @(posedge clock) begin
    if (srst || !(frame_strobe && sclk && sda)) begin
      idle_cnt_r <= 8'h00;
    end else if (idle_cnt_r != 8'hff) begin
      idle_cnt_r <= idle_cnt_r + 8'h01;
    end
  end
  no_high_drive_a: assert property (!dev_sda_o && !host_sda_o)
    else $error("data line driven high");
  quiet_idle_a: assert property (frame_strobe && $past(frame_strobe, 4) |-> !dev_sda_oe)
    else $error("device pulls data outside a transfer");
  no_clash_a: assert property (dev_sda_oe |-> !host_sda_oe)
    else $error("both ends pull data at once");
  hold_at_fall_a: assert property ($fell(sclk) |-> $stable(host_sda_oe) && $stable(dev_sda_oe))
    else $error("data moved at the sampling edge");
  start_edge_a: assert property ($fell(frame_strobe) |-> sclk && $past(sclk))
    else $error("strobe fell with clock low");
  end_edge_a: assert property ($rose(frame_strobe) |-> sclk && $past(sclk) && sda)
    else $error("strobe rose before clock and data high");
  idle_gap_a: assert property ($rose(frame_strobe) |-> (frame_strobe && sclk && sda)[*8])
    else $error("lines not idle high after a transfer");
  low_half_a: assert property ($fell(sclk) |-> (!sclk)[*8] ##1 !sclk ##1 !sclk ##1 sclk)
    else $error("serial clock low phase not ten cycles");
  bit_count_a: assert property ($rose(frame_strobe) |-> fall_cnt_r == 6'h1b)
    else $error("transfer bit count wrong");
  idle_len_a: assert property ($fell(frame_strobe) |-> idle_cnt_r >= IDLE_MIN)
    else $error("idle gap before a transfer too short");
endmodule
`default_nettype wire

// File: test/tb_three_line_serial_control_slave.sv
// self-checking bench: host end talks to one device end, bench bit-bangs a second
// assumes the package and interface are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_three_line_serial_control_slave;
  localparam logic [5:0] MY_ID = 6'h2d; // arbitrary identity value
  logic clock; // system clock
  logic srst; // synchronous reset
  logic req_valid, req_ready, req_write, rsp_valid; // host request handshake
  logic [5:0] req_id; // target identity
  logic [6:0] req_addr; // register address
  logic [7:0] req_wdata, rsp_rdata, rd; // data in and out
  logic [7:0] blk_a, flt_a, vco_a, blk_b, flt_b, vco_b; // device registers
  logic busy_a, busy_b; // transfer in progress
  logic [26:0] mon_r; // last bits seen on the link at clock falls
  logic [8:0] hdr; // good header for the bit-banged end
  int bad_count, n_checks, cyc; // tallies and cycle count
  tlsc_if link_a (); // design ends face each other here
  tlsc_if link_b (); // bench acts as host here
  tlsc_host tlsc_host_i (.clock(clock), .srst(srst), .link(link_a), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_id(req_id), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata));
  tlsc_dev #(.SLAVE_ID(MY_ID)) tlsc_dev_i (.clock(clock), .srst(srst), .link(link_a),
    .block_ctl(blk_a), .filter_sel(flt_a), .vco_ctl(vco_a), .busy(busy_a));
  tlsc_dev #(.SLAVE_ID(MY_ID)) tlsc_dev_x_i (.clock(clock), .srst(srst), .link(link_b),
    .block_ctl(blk_b), .filter_sel(flt_b), .vco_ctl(vco_b), .busy(busy_b));
  tlsc_link_sva tlsc_link_sva_i (.clock(clock), .srst(srst),
    .frame_strobe(link_a.frame_strobe), .sclk(link_a.sclk), .host_sda_o(link_a.host_sda_o),
    .host_sda_oe(link_a.host_sda_oe), .dev_sda_o(link_a.dev_sda_o),
    .dev_sda_oe(link_a.dev_sda_oe), .sda(link_a.sda));
  // free-running system clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // capture the wire at each sampling edge inside a transfer
  always @(negedge link_a.sclk) begin
    if (!link_a.frame_strobe) mon_r <= {mon_r[25:0], link_a.sda};
  end
  // cut a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      bad_count++;
      report_and_stop();
    end
  end
  // compare and tally
  task automatic chk(input logic [26:0] got, input logic [26:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one host frame; d is write data, or the byte expected back on a read
  task automatic xfer(input logic w, input logic [5:0] id, input logic [6:0] a,
      input logic [7:0] d);
    int n;
    @(negedge clock);
    req_valid = 1'b1;
    req_write = w;
    req_id = id;
    req_addr = a;
    req_wdata = w ? d : 8'h00;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin
      @(negedge clock);
      n++;
    end
    chk({26'h0, req_ready}, 27'h1);
    chk({26'h0, busy_a}, 27'h0);
    @(negedge clock);
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    chk({26'h0, rsp_valid}, 27'h1);
    rd = rsp_rdata;
    chk({19'h0, rd}, {19'h0, w ? 8'h00 : d});
    chk(mon_r, {tlsc_pkg::PREFIX, id, 1'b1, w, a, 1'b1, d, 1'b1});
  endtask
  // write frame for the bit-banged end
  function automatic logic [17:0] wfr(input logic [6:0] a, input logic [7:0] d);
    return {tlsc_pkg::DIR_WRITE, a, 1'b1, d, 1'b1};
  endfunction
  // drive n bits msb first at a 160 ns serial clock; stb held high aborts framing
  task automatic bb_send(input logic [44:0] bits, input int n, input logic stb);
    @(negedge clock);
    link_b.frame_strobe = stb;
    repeat (10) @(negedge clock);
    for (int i = 0; i < n; i++) begin
      if (i == 9) chk({26'h0, busy_b}, {26'h0, ~stb});
      link_b.host_sda_oe = ~bits[44 - i];
      link_b.sclk = 1'b1;
      repeat (10) @(negedge clock);
      link_b.sclk = 1'b0;
      repeat (10) @(negedge clock);
    end
    link_b.host_sda_oe = 1'b0;
    link_b.sclk = 1'b1;
    repeat (10) @(negedge clock);
    link_b.frame_strobe = 1'b1;
    repeat (20) @(negedge clock);
  endtask
  // verdict and end of run
  task automatic report_and_stop();
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    {req_valid, req_write, req_id, req_addr, req_wdata, mon_r} = '0;
    {link_b.host_sda_o, link_b.host_sda_oe} = 2'b00;
    {link_b.frame_strobe, link_b.sclk} = 2'b11;
    {bad_count, n_checks, cyc} = '0;
    hdr = {tlsc_pkg::PREFIX, MY_ID, 1'b1};
    srst = 1'b1;
    repeat (2) @(negedge clock);
    srst = 1'b0;
    chk({3'h0, blk_a, flt_a, vco_a}, {3'h0, 8'h08, 8'h1c, 8'h0b});
    xfer(tlsc_pkg::DIR_READ, MY_ID, tlsc_pkg::A_BLOCK, tlsc_pkg::D_BLOCK);
    xfer(tlsc_pkg::DIR_READ, MY_ID, tlsc_pkg::A_FILTER, tlsc_pkg::D_FILTER);
    xfer(tlsc_pkg::DIR_READ, MY_ID, tlsc_pkg::A_ID, {2'b00, MY_ID});
    xfer(tlsc_pkg::DIR_READ, MY_ID, 7'h7f, 8'h00);
    xfer(tlsc_pkg::DIR_READ, MY_ID, tlsc_pkg::A_RESET, 8'h00);
    xfer(tlsc_pkg::DIR_WRITE, MY_ID, tlsc_pkg::A_BLOCK, 8'ha5);
    xfer(tlsc_pkg::DIR_WRITE, MY_ID, tlsc_pkg::A_FILTER, 8'h3c);
    xfer(tlsc_pkg::DIR_WRITE, MY_ID, tlsc_pkg::A_VCO, 8'hf0);
    xfer(tlsc_pkg::DIR_WRITE, MY_ID, tlsc_pkg::A_ID, 8'h00);
    xfer(tlsc_pkg::DIR_WRITE, MY_ID, 7'h7f, 8'h5a);
    xfer(tlsc_pkg::DIR_WRITE, ~MY_ID, tlsc_pkg::A_BLOCK, 8'h11);
    chk({3'h0, blk_a, flt_a, vco_a}, {3'h0, 8'ha5, 8'h3c, 8'hf0});
    xfer(tlsc_pkg::DIR_READ, ~MY_ID, tlsc_pkg::A_VCO, 8'hff);
    xfer(tlsc_pkg::DIR_READ, MY_ID, tlsc_pkg::A_VCO, 8'hf0);
    xfer(tlsc_pkg::DIR_READ, MY_ID, tlsc_pkg::A_ID, {2'b00, MY_ID});
    xfer(tlsc_pkg::DIR_WRITE, MY_ID, tlsc_pkg::A_RESET, 8'h00);
    chk({3'h0, blk_a, flt_a, vco_a}, {3'h0, 8'h08, 8'h1c, 8'h0b});
    // two frames under one strobe on the second link
    bb_send({hdr, wfr(tlsc_pkg::A_BLOCK, 8'h11), wfr(tlsc_pkg::A_FILTER, 8'h22)}, 45, 1'b0);
    chk({3'h0, blk_b, flt_b, vco_b}, {3'h0, 8'h11, 8'h22, 8'h0b});
    bb_send({2'b10, MY_ID, 1'b1, wfr(tlsc_pkg::A_VCO, 8'h33), 18'h0}, 27, 1'b0);
    chk({3'h0, blk_b, flt_b, vco_b}, {3'h0, 8'h11, 8'h22, 8'h0b});
    bb_send({hdr, wfr(tlsc_pkg::A_VCO, 8'h44), 18'h0}, 27, 1'b1);
    chk({3'h0, blk_b, flt_b, vco_b}, {3'h0, 8'h11, 8'h22, 8'h0b});
    bb_send({hdr, wfr(tlsc_pkg::A_VCO, 8'h55), 18'h0}, 27, 1'b0);
    chk({3'h0, blk_b, flt_b, vco_b}, {3'h0, 8'h11, 8'h22, 8'h55});
    report_and_stop();
  end
endmodule
`default_nettype wire
